// [rtl/phy_status_defs.vh]
// constants for the phy status summary register block
`ifndef PHY_STATUS_DEFS_VH
`define PHY_STATUS_DEFS_VH

// ----------------------------------------------------------------
// management register addresses (5-bit register number)
// ----------------------------------------------------------------
`define ADDR_W 5
`define ADDR_BASIC_MODE_STATUS 5'h01
`define ADDR_NEGOTIATION_EXPANSION 5'h06
`define ADDR_PHY_STATUS_SUMMARY 5'h10
`define ADDR_INTERRUPT_STATUS_REG 5'h12
`define ADDR_FALSE_CARRIER_COUNTER 5'h14
`define ADDR_RECEIVE_ERROR_COUNTER 5'h15
`define ADDR_TEN_MBPS_STATUS_CONTROL 5'h1a

// ----------------------------------------------------------------
// phy_status_summary field positions
// ----------------------------------------------------------------
`define DATA_W 16
`define BIT_RESERVED 15
`define BIT_CROSSOVER 14
`define BIT_RX_ERROR 13
`define BIT_POLARITY 12
`define BIT_FALSE_CARRIER 11
`define BIT_SIGNAL_DETECT 10
`define BIT_DESCRAMBLER_LOCK 9
`define BIT_PAGE_RECEIVED 8
`define BIT_INT_PENDING 7
`define BIT_REMOTE_FAULT 6
`define BIT_JABBER 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STATUS_SUMMARY_RESET 16'h0000
`define STICKY_COUNT 7
`define STICKY_RESET 7'h00

`endif

// [rtl/sticky_flags.v]
// bank of sticky event flags, set wins over clear
`timescale 1ns/1ps

module sticky_flags #(
  parameter WIDTH = 7
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  output reg [WIDTH-1:0] flag_q
);

  wire [WIDTH-1:0] flag_d;

  // an event landing in the clearing cycle must not be lost
  assign flag_d = set | (flag_q & ~clr);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_q <= {WIDTH{1'b0}};
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// [rtl/phy_status_summary.v]
// status summary register of a 10/100 transceiver, bits 15 down to 5
`timescale 1ns/1ps
`include "phy_status_defs.vh"

module phy_status_summary (
  input wire ref_clk,
  input wire rst_n,
  // management register access
  input wire rd_strobe,
  input wire wr_strobe,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] wr_data,
  output reg [`DATA_W-1:0] rd_data_q,
  output reg rd_valid_q,
  output reg rd_hit_q,
  // crossover control and state
  input wire auto_crossover_enable,
  input wire crossover_force,
  input wire crossover_algo_swap,
  // receive and link events
  input wire rx_error_event,
  input wire false_carrier_event,
  input wire polarity_inverted,
  input wire signal_detect,
  input wire descrambler_lock,
  input wire page_received_event,
  input wire interrupt_event,
  input wire remote_fault_event,
  input wire jabber_event,
  input wire speed_10_mode,
  // live summary word for other logic
  output reg [`DATA_W-1:0] status_word_q,
  output reg crossover_swapped_q
);

  // ----------------------------------------------------------------
  // sticky flag indices
  // ----------------------------------------------------------------
  localparam [2:0] IDX_RX_ERROR = 3'h0;
  localparam [2:0] IDX_FALSE_CARRIER = 3'h1;
  localparam [2:0] IDX_POLARITY = 3'h2;
  localparam [2:0] IDX_PAGE = 3'h3;
  localparam [2:0] IDX_INTERRUPT = 3'h4;
  localparam [2:0] IDX_REMOTE_FAULT = 3'h5;
  localparam [2:0] IDX_JABBER = 3'h6;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function rd_of;
    input strobe;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      rd_of = strobe & (addr == target);
    end
  endfunction

  wire rd_summary;

  assign rd_summary = rd_of(rd_strobe, reg_addr, `ADDR_PHY_STATUS_SUMMARY);

  // ----------------------------------------------------------------
  // clear-on-read decode
  // ----------------------------------------------------------------
  // each flag empties only on a read of the register it mirrors, never on
  // a summary read, so polling the summary cannot lose an event
  function [`STICKY_COUNT-1:0] clear_mask;
    input strobe;
    input [`ADDR_W-1:0] addr;
    reg [`STICKY_COUNT-1:0] m;
    begin
      m = `STICKY_RESET;
      case (addr)
        `ADDR_RECEIVE_ERROR_COUNTER: begin
          m[IDX_RX_ERROR] = 1'b1;
        end
        `ADDR_FALSE_CARRIER_COUNTER: begin
          m[IDX_FALSE_CARRIER] = 1'b1;
        end
        `ADDR_TEN_MBPS_STATUS_CONTROL: begin
          m[IDX_POLARITY] = 1'b1;
        end
        `ADDR_NEGOTIATION_EXPANSION: begin
          m[IDX_PAGE] = 1'b1;
        end
        `ADDR_INTERRUPT_STATUS_REG: begin
          m[IDX_INTERRUPT] = 1'b1;
        end
        // one basic status read empties remote fault and jabber together
        `ADDR_BASIC_MODE_STATUS: begin
          m[IDX_REMOTE_FAULT] = 1'b1;
          m[IDX_JABBER] = 1'b1;
        end
        default: begin
          m = `STICKY_RESET;
        end
      endcase
      if (!strobe) begin
        m = `STICKY_RESET;
      end
      clear_mask = m;
    end
  endfunction

  // ----------------------------------------------------------------
  // crossover state
  // ----------------------------------------------------------------
  reg crossover_d;

  // force wins over the automatic algorithm, even with auto off; with both
  // off the pairs stay in their normal assignment
  // the live algorithm value passes straight through, so the bit tracks
  // each toggle of the algorithm one cycle later
  function crossover_select;
    input force_swap;
    input auto_en;
    input algo_swap;
    begin
      case ({force_swap, auto_en})
        2'b11: begin
          crossover_select = 1'b1;
        end
        2'b10: begin
          crossover_select = 1'b1;
        end
        2'b01: begin
          crossover_select = algo_swap;
        end
        default: begin
          crossover_select = 1'b0;
        end
      endcase
    end
  endfunction

  always @* begin
    crossover_d = crossover_select(crossover_force, auto_crossover_enable,
                                   crossover_algo_swap);
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      crossover_swapped_q <= 1'b0;
    end else begin
      crossover_swapped_q <= crossover_d;
    end
  end

  // ----------------------------------------------------------------
  // sticky event flags
  // ----------------------------------------------------------------
  reg [`STICKY_COUNT-1:0] sticky_set;
  reg [`STICKY_COUNT-1:0] sticky_clr;
  wire [`STICKY_COUNT-1:0] sticky_q;

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------

  // jabber has no meaning at 100 Mb/s, so it is not caught there
  function [`STICKY_COUNT-1:0] set_mask;
    input rx_err;
    input false_car;
    input pol_inv;
    input page_rx;
    input irq;
    input rem_fault;
    input jabber;
    input ten_mbps;
    reg [`STICKY_COUNT-1:0] m;
    begin
      m = `STICKY_RESET;
      m[IDX_RX_ERROR] = rx_err;
      m[IDX_FALSE_CARRIER] = false_car;
      m[IDX_POLARITY] = pol_inv;
      m[IDX_PAGE] = page_rx;
      m[IDX_INTERRUPT] = irq;
      m[IDX_REMOTE_FAULT] = rem_fault;
      m[IDX_JABBER] = jabber & ten_mbps;
      set_mask = m;
    end
  endfunction

  always @* begin
    sticky_set = set_mask(rx_error_event, false_carrier_event, polarity_inverted,
                          page_received_event, interrupt_event, remote_fault_event,
                          jabber_event, speed_10_mode);
    sticky_clr = clear_mask(rd_strobe, reg_addr);
  end

  sticky_flags #(
    .WIDTH(`STICKY_COUNT)
  ) u_sticky (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .set(sticky_set),
    .clr(sticky_clr),
    .flag_q(sticky_q)
  );

  // ----------------------------------------------------------------
  // latching-low indications
  // ----------------------------------------------------------------
  reg signal_detect_ll_q;
  reg descrambler_lock_ll_q;
  reg signal_detect_ll_d;
  reg descrambler_lock_ll_d;

  // a low is held until the summary is read; the read itself shows the
  // held value and the latch then restarts from the live level
  // ----------------------------------------------------------------
  // latching-low helper
  // ----------------------------------------------------------------
  // one shared helper keeps the two latches from drifting apart
  function latch_low_next;
    input reload;
    input held;
    input live;
    begin
      if (reload) begin
        latch_low_next = live;
      end else begin
        latch_low_next = held & live;
      end
    end
  endfunction

  always @* begin
    signal_detect_ll_d = latch_low_next(rd_summary, signal_detect_ll_q,
                                        signal_detect);
    descrambler_lock_ll_d = latch_low_next(rd_summary, descrambler_lock_ll_q,
                                           descrambler_lock);
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      signal_detect_ll_q <= 1'b0;
      descrambler_lock_ll_q <= 1'b0;
    end else begin
      signal_detect_ll_q <= signal_detect_ll_d;
      descrambler_lock_ll_q <= descrambler_lock_ll_d;
    end
  end

  // ----------------------------------------------------------------
  // summary word assembly
  // ----------------------------------------------------------------
  function [`DATA_W-1:0] pack_summary;
    input xover;
    input [`STICKY_COUNT-1:0] flags;
    input sd_ll;
    input dl_ll;
    reg [`DATA_W-1:0] w;
    begin
      w = `STATUS_SUMMARY_RESET;
      w[`BIT_RESERVED] = 1'b0;
      w[`BIT_CROSSOVER] = xover;
      w[`BIT_RX_ERROR] = flags[IDX_RX_ERROR];
      w[`BIT_POLARITY] = flags[IDX_POLARITY];
      w[`BIT_FALSE_CARRIER] = flags[IDX_FALSE_CARRIER];
      w[`BIT_SIGNAL_DETECT] = sd_ll;
      w[`BIT_DESCRAMBLER_LOCK] = dl_ll;
      w[`BIT_PAGE_RECEIVED] = flags[IDX_PAGE];
      w[`BIT_INT_PENDING] = flags[IDX_INTERRUPT];
      w[`BIT_REMOTE_FAULT] = flags[IDX_REMOTE_FAULT];
      w[`BIT_JABBER] = flags[IDX_JABBER];
      pack_summary = w;
    end
  endfunction

  wire [`DATA_W-1:0] summary_now;

  assign summary_now = pack_summary(crossover_swapped_q, sticky_q,
                                    signal_detect_ll_q, descrambler_lock_ll_q);

  // other logic sees the word a cycle late; reads take the unregistered
  // word so a read never returns a flag one cycle stale
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      status_word_q <= `STATUS_SUMMARY_RESET;
    end else begin
      status_word_q <= summary_now;
    end
  end

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  // only the summary lives here; every other register number answers
  // zero so a stray read cannot show a neighbour's state
  function [`DATA_W-1:0] read_word;
    input [`ADDR_W-1:0] addr;
    input [`DATA_W-1:0] summary;
    begin
      case (addr)
        `ADDR_PHY_STATUS_SUMMARY: begin
          read_word = summary;
        end
        default: begin
          read_word = `STATUS_SUMMARY_RESET;
        end
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // the register is read-only, so writes to any bit leave no trace
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_data_q <= `STATUS_SUMMARY_RESET;
      rd_valid_q <= 1'b0;
      rd_hit_q <= 1'b0;
    end else begin
      // valid answers every strobe, mapped or not, so a master never waits
      rd_valid_q <= rd_strobe;
      rd_hit_q <= rd_summary;
      if (rd_strobe) begin
        rd_data_q <= read_word(reg_addr, summary_now);
      end
    end
  end

endmodule

// [test/phy_status_summary_asserts.sv]
// checker for the phy status summary register block
`timescale 1ns/1ps
`include "phy_status_defs.vh"

module phy_status_chk (
  input wire ref_clk,
  input wire rst_n,
  input wire rd_strobe,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] rd_data_q,
  input wire rd_valid_q,
  input wire rd_hit_q,
  input wire auto_crossover_enable,
  input wire crossover_force,
  input wire crossover_algo_swap,
  input wire crossover_swapped_q,
  input wire rx_error_event,
  input wire false_carrier_event,
  input wire signal_detect
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // read port and fields
  // ----------------------------------------------------------------
  a_read_hit: assert property (rd_strobe && reg_addr == 5'h10 |=> rd_valid_q && rd_hit_q)
    else $error("summary read not answered");
  a_reserved_zero: assert property (rd_hit_q |-> !rd_data_q[15] && rd_data_q[4:0] == 5'h0)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (rd_valid_q && !rd_hit_q |-> rd_data_q == 16'h0000)
    else $error("unmapped read not zero");
  a_xover_forced: assert property (crossover_force |=> crossover_swapped_q)
    else $error("forced crossover not reported");
  a_xover_live: assert property (!crossover_force && auto_crossover_enable
    |=> crossover_swapped_q == $past(crossover_algo_swap))
    else $error("crossover does not follow algorithm");
  a_rxerr_sets: assert property (rx_error_event ##1 !(rd_strobe && reg_addr == 5'h15)
    ##1 (rd_strobe && reg_addr == 5'h10) |=> rd_data_q[13])
    else $error("receive error latch not set");
  // the event is kept low across the gap so that set-wins cannot mask the clear
  a_rxerr_clears: assert property ((rd_strobe && reg_addr == 5'h15 && !rx_error_event)
    ##1 !rx_error_event ##1 (rd_strobe && reg_addr == 5'h10) |=> !rd_data_q[13])
    else $error("receive error latch not cleared");
  a_fcar_clears: assert property ((rd_strobe && reg_addr == 5'h14 && !false_carrier_event)
    ##1 !false_carrier_event ##1 (rd_strobe && reg_addr == 5'h10) |=> !rd_data_q[11])
    else $error("false carrier latch not cleared");
  a_sd_latch_low: assert property ((!signal_detect && !rd_strobe) ##1 !rd_strobe
    ##1 (rd_strobe && reg_addr == 5'h10) |=> !rd_data_q[10])
    else $error("signal detect low not latched");
endmodule

bind phy_status_summary phy_status_chk chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .rd_strobe(rd_strobe), .reg_addr(reg_addr), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .rd_hit_q(rd_hit_q), .auto_crossover_enable(auto_crossover_enable),
  .crossover_force(crossover_force), .crossover_algo_swap(crossover_algo_swap),
  .crossover_swapped_q(crossover_swapped_q), .rx_error_event(rx_error_event),
  .false_carrier_event(false_carrier_event), .signal_detect(signal_detect));

// [test/mgmt_master.sv]
// station management side model issuing register reads and writes
`timescale 1ns/1ps

module mgmt_master (
  input wire ref_clk,
  input wire [15:0] rd_data_q,
  output reg rd_strobe,
  output reg wr_strobe,
  output reg [4:0] reg_addr,
  output reg [15:0] wr_data
);
  // after an access the idle address, and after a write also the data, are inverted so stale values never look valid
  initial begin
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    reg_addr = 5'h1f;
    wr_data = 16'h0000;
  end
  task rd(input [4:0] a, output [15:0] d);
    begin
      @(posedge ref_clk);
      #1 rd_strobe = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #1 rd_strobe = 1'b0;
      reg_addr = ~a;
      d = rd_data_q;
    end
  endtask
  task wr(input [4:0] a, input [15:0] v);
    begin
      @(posedge ref_clk);
      #1 wr_strobe = 1'b1;
      reg_addr = a;
      wr_data = v;
      @(posedge ref_clk);
      #1 wr_strobe = 1'b0;
      reg_addr = ~a;
      wr_data = ~v;
    end
  endtask
endmodule

// [test/phy_status_summary_tb.sv]
// self-checking testbench for the phy status summary register
`timescale 1ns/1ps
`include "phy_status_defs.vh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end

module phy_status_summary_tb;
  reg ref_clk = 0, rst_n = 0, ae = 0, cf = 0, cs = 0, sd = 0, dl = 0, sp = 0;
  reg [6:0] ev = 0;
  reg [15:0] d, mk;
  wire [15:0] rd_data_q, wr_data, sw;
  wire [4:0] reg_addr;
  wire rd_valid_q, rd_hit_q, rd_strobe, wr_strobe, xo;
  int err_count = 0, compares = 0, cyc = 0, i;
  // clearing address and bit position of each sticky source, ev[0] first
  localparam [34:0] CA = {5'h01, 5'h01, 5'h12, 5'h06, 5'h14, 5'h1a, 5'h15};
  localparam [27:0] BP = {4'h5, 4'h6, 4'h7, 4'h8, 4'hb, 4'hc, 4'hd};
  always #12.5 ref_clk = ~ref_clk;
  mgmt_master m (.ref_clk(ref_clk), .rd_data_q(rd_data_q), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .reg_addr(reg_addr), .wr_data(wr_data));
  phy_status_summary dut (.ref_clk(ref_clk), .rst_n(rst_n), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .reg_addr(reg_addr), .wr_data(wr_data), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .rd_hit_q(rd_hit_q), .auto_crossover_enable(ae),
    .crossover_force(cf), .crossover_algo_swap(cs), .rx_error_event(ev[0]),
    .false_carrier_event(ev[2]), .polarity_inverted(ev[1]), .signal_detect(sd),
    .descrambler_lock(dl), .page_received_event(ev[3]), .interrupt_event(ev[4]),
    .remote_fault_event(ev[5]), .jabber_event(ev[6]), .speed_10_mode(sp),
    .status_word_q(sw), .crossover_swapped_q(xo));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task final_report;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task rdc(input [4:0] a, input [15:0] msk, input [15:0] e);
    begin
      m.rd(a, d);
      `CHK(rd_valid_q, 1'b1)
      `CHK(rd_hit_q, a == 5'h10)
      `CHK(d & msk, e)
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report;
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1;
    rdc(5'h10, 16'hffff, 16'h0000);
    m.wr(5'h10, 16'hffff);
    rdc(5'h10, 16'h801f, 16'h0000);
    rdc(5'h03, 16'hffff, 16'h0000);
    $display("test reset and reserved done");
    for (i = 0; i < 8; i++) begin
      {cf, ae, cs} = i;
      repeat (2) @(posedge ref_clk);
      #1 `CHK(xo, cf | (ae & cs))
      rdc(5'h10, 16'h4000, {1'b0, cf | (ae & cs), 14'h0});
    end
    $display("test crossover done");
    {cf, ae, cs} = 3'h0;
    sp = 1;
    for (i = 0; i < 7; i++) begin
      mk = 16'h0001 << BP[i*4+:4];
      ev[i] = 1;
      @(posedge ref_clk);
      #1 ev[i] = 0;
      rdc(5'h10, mk, mk);
      `CHK(sw & mk, mk)
      rdc(5'h10, mk, mk);
      m.rd(CA[i*5+:5], d);
      rdc(5'h10, mk, 16'h0000);
      `CHK(sw & mk, 16'h0000)
    end
    sp = 0;
    ev[6] = 1;
    ev[5] = 1;
    @(posedge ref_clk);
    #1 ev = 0;
    rdc(5'h10, 16'h0020, 16'h0000);
    rst_n = 0;
    @(posedge ref_clk);
    #1 rst_n = 1;
    rdc(5'h10, 16'hffff, 16'h0000);
    $display("test sticky bits done");
    sd = 1;
    dl = 1;
    rdc(5'h10, 16'h0600, 16'h0000);
    rdc(5'h10, 16'h0600, 16'h0600);
    sd = 0;
    @(posedge ref_clk);
    #1 sd = 1;
    rdc(5'h10, 16'h0600, 16'h0200);
    rdc(5'h10, 16'h0600, 16'h0600);
    $display("test latching low done");
    final_report;
  end
endmodule
